// *** design/port_ctrl_pkg.sv ***
// Constants and carrier types for the device-mode port control fields.
// Assumes a classic Wishbone slave with 32-bit data and one clock.
// How it works
// - Two-bit indicator field, read-write, reset zero: off, amber, green, undefined.
// - Writing the indicator field also updates the indicator output register.
// - Four-bit test field, read-write, reset zero; nonzero means test mode.
// - Test codes: J, K, NAK, packet, forced HS, forced FS; others invalid.
// - A forced-enable code at once marks the port connected and enabled.
// - Writing code zero lets port state machines continue from their state.
// - Three wake-enable bits always read zero and do nothing in device role.
// - Writing one to the clock-disable bit gates the PHY clock; reads one.
// - Writing zero re-enables the PHY clock; reads zero; resets to zero.
// - A host resume clears the clock-disable bit and restores the clock.
package port_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_REG_OFS   = 8'h00; // port_status_control
  localparam logic [7:0] IND_OUT_OFS    = 8'h04; // indicator_output_reg
  localparam logic [7:0] STATUS_OFS     = 8'h08; // port drive status
  localparam int         IND_LSB        = 14;
  localparam int         TEST_LSB       = 16;
  localparam int         WAKE_CN_BIT    = 20;
  localparam int         WAKE_DC_BIT    = 21;
  localparam int         WAKE_OC_BIT    = 22;
  localparam int         CLK_OFF_BIT    = 23;
  localparam logic [1:0] IND_RESET      = 2'h0;
  localparam logic [3:0] TEST_RESET     = 4'h0;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] IND_OFF        = 2'h0;
  localparam logic [1:0] IND_AMBER      = 2'h1;
  localparam logic [1:0] IND_GREEN      = 2'h2;
  localparam logic [3:0] TEST_DISABLE   = 4'h0;
  localparam logic [3:0] TEST_J         = 4'h1;
  localparam logic [3:0] TEST_K         = 4'h2;
  localparam logic [3:0] TEST_NAK       = 4'h3;
  localparam logic [3:0] TEST_PACKET    = 4'h4;
  localparam logic [3:0] forced_highspeed_code = 4'h5;
  localparam logic [3:0] forced_fullspeed_code = 4'h6;

  // Pattern driven toward the line logic
  typedef enum logic [2:0] {PAT_NONE, PAT_J, PAT_K, PAT_NAK, PAT_PACKET} pattern_e;

  // Indicator lamp outputs
  typedef struct packed {
    logic amber;
    logic green;
  } lamp_s;

  // Forced connection request toward port state machines
  typedef struct packed {
    logic force_en;   // Hold port connected and enabled
    logic highspeed;  // Selected speed: 1 HS, 0 FS
  } force_s;

  // All block state
  typedef struct packed {
    logic [1:0] indicator_select;
    logic [1:0] ind_out;
    logic [3:0] test_control;
    logic       phy_clock_disable;
    logic       ack;
    logic [31:0] rdata;
    logic       resume_s1;
    logic       resume_s2;
  } state_s;

endpackage

// *** design/usb_port_ctrl_device_fields.sv ***
// Device-mode indicator, test control and PHY clock gating fields.
// Assumes Wishbone classic master; resume level arrives asynchronous.
`timescale 1ns/100ps
module usb_port_ctrl_device_fields (
  // Clock and reset
  input  wire  logic                    core_clk_i,
  input  wire  logic                    arst_n_i,
  // Wishbone slave
  input  wire  logic                    wb_cyc_i,
  input  wire  logic                    wb_stb_i,
  input  wire  logic                    wb_we_i,
  input  wire  logic [7:0]              wb_adr_i,
  input  wire  logic [3:0]              wb_sel_i,
  input  wire  logic [31:0]             wb_dat_i,
  output logic       [31:0]             wb_dat_o,
  output logic                          wb_ack_o,
  // Link side
  input  wire  logic                    host_resume_i,
  input  wire  logic                    phy_clk_i,
  output logic                          phy_clk_o,
  output logic                          phy_clk_gated_o,
  output port_ctrl_pkg::lamp_s          lamp_o,
  output port_ctrl_pkg::force_s         force_o,
  output port_ctrl_pkg::pattern_e       pattern_o,
  output logic                          test_mode_o
);
  import port_ctrl_pkg::*;

  state_s q;
  state_s d;
  logic   hit;
  logic   wr;
  logic   resume_seen;
  logic [31:0] port_reg_rd;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Request taken on first edge; a write lands on the edge that sees ack
  assign hit = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr  = wb_cyc_i & wb_stb_i & q.ack & wb_we_i;
  assign resume_seen = q.resume_s2;

  // Assemble the port register; wake bits stay zero
  always_comb begin
    port_reg_rd = 32'h0000_0000;
    port_reg_rd[IND_LSB +: 2]  = q.indicator_select;
    port_reg_rd[TEST_LSB +: 4] = q.test_control;
    port_reg_rd[WAKE_CN_BIT]   = 1'b0;
    port_reg_rd[WAKE_DC_BIT]   = 1'b0;
    port_reg_rd[WAKE_OC_BIT]   = 1'b0;
    port_reg_rd[CLK_OFF_BIT]   = q.phy_clock_disable;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.resume_s1 = host_resume_i;
    d.resume_s2 = q.resume_s1;
    d.ack = hit;
    if (hit && !wb_we_i) begin
      unique case (wb_adr_i)
        PORT_REG_OFS: d.rdata = port_reg_rd;
        IND_OUT_OFS: d.rdata = {30'h0, q.ind_out};
        STATUS_OFS: d.rdata = {28'h0, test_mode_o, force_o.force_en,
                               force_o.highspeed, q.phy_clock_disable};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr && wb_adr_i == PORT_REG_OFS) begin
      if (wb_sel_i[1]) begin
        d.indicator_select = wb_dat_i[IND_LSB +: 2];
        d.ind_out = wb_dat_i[IND_LSB +: 2];
      end
      if (wb_sel_i[2]) begin
        d.test_control = wb_dat_i[TEST_LSB +: 4];
        d.phy_clock_disable = wb_dat_i[CLK_OFF_BIT];
      end
    end
    if (wr && wb_adr_i == IND_OUT_OFS && wb_sel_i[0]) begin
      d.ind_out = wb_dat_i[1:0];
    end
    // Host resume wins over a software write
    if (resume_seen) begin
      d.phy_clock_disable = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.indicator_select <= IND_RESET;
      q.test_control <= TEST_RESET;
      q.phy_clock_disable <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;

  // Clock gate: low while disabled, runs again when cleared
  assign phy_clk_gated_o = q.phy_clock_disable;
  assign phy_clk_o = phy_clk_i & ~q.phy_clock_disable;

  // Lamp decode; code 11 lights nothing
  assign lamp_o.amber = (q.ind_out == IND_AMBER);
  assign lamp_o.green = (q.ind_out == IND_GREEN);

  // Test field decode
  assign test_mode_o = (q.test_control != TEST_DISABLE);

  // Forced enable; dropping it returns control to port logic as is
  always_comb begin
    force_o.force_en = 1'b0;
    force_o.highspeed = 1'b0;
    pattern_o = PAT_NONE;
    unique case (q.test_control)
      TEST_J: pattern_o = PAT_J;
      TEST_K: pattern_o = PAT_K;
      TEST_NAK: pattern_o = PAT_NAK;
      TEST_PACKET: pattern_o = PAT_PACKET;
      forced_highspeed_code: begin
        force_o.force_en = 1'b1;
        force_o.highspeed = 1'b1;
      end
      forced_fullspeed_code: force_o.force_en = 1'b1;
      default: pattern_o = PAT_NONE;
    endcase
  end

endmodule

// *** test/usb_host_model.sv ***
// Far side model: PHY clock source and host resume signalling.
// Assumes the bench commands resume; the PHY clock runs free.
`timescale 1ns/100ps
module usb_host_model (
  // Bench control
  input  wire logic resume_req_i,
  // Toward the block
  output logic      phy_clk_o,
  output logic      resume_o
);
  // Free PHY clock, phase unrelated to the core clock
  initial phy_clk_o = 1'b0;
  always #2.1 phy_clk_o = ~phy_clk_o;
  // Resume level held as long as the bench asks
  assign resume_o = resume_req_i;
endmodule

// *** test/usb_port_ctrl_monitor.sv ***
// Checker for the port control fields, bound to the top module.
// Assumes one clock domain and a one-cycle Wishbone answer.
`timescale 1ns/100ps
module usb_port_ctrl_monitor (
  // Clock, reset and bus
  input wire logic                    core_clk_i,
  input wire logic                    arst_n_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_ack_o,
  input wire logic [31:0]             wb_dat_o,
  // Link side
  input wire logic                    host_resume_i,
  input wire logic                    phy_clk_i,
  input wire logic                    phy_clk_o,
  input wire logic                    phy_clk_gated_o,
  input wire port_ctrl_pkg::force_s   force_o,
  input wire port_ctrl_pkg::pattern_e pattern_o,
  input wire logic                    test_mode_o
);
  import port_ctrl_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_gate_low: assert property (phy_clk_gated_o |-> !phy_clk_o)
    else $error("PHY clock runs while gated");
  a_clk_pass: assert property (!phy_clk_gated_o |-> phy_clk_o == phy_clk_i)
    else $error("PHY clock blocked while enabled");
  a_pattern_test: assert property (pattern_o != PAT_NONE |-> test_mode_o && !force_o.force_en)
    else $error("pattern outside test mode");
  a_force_test: assert property (force_o.force_en |-> test_mode_o && pattern_o == PAT_NONE)
    else $error("force outside test mode");
  a_wake_zero: assert property (wb_ack_o |-> wb_dat_o[22:20] == 3'h0)
    else $error("wake bits read nonzero");
  a_resume_clear: assert property (host_resume_i [*5] |-> !phy_clk_gated_o)
    else $error("resume left PHY clock gated");
endmodule
bind usb_port_ctrl_device_fields usb_port_ctrl_monitor u_mon (.*);

// *** test/usb_port_ctrl_device_fields_bench.sv ***
// Bench for the port control fields: Wishbone tasks and field checks.
// Assumes the host model beside the block and a one-clock design.
`timescale 1ns/100ps
module usb_port_ctrl_device_fields_bench;
  import port_ctrl_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, host_resume_i, phy_clk_i, phy_clk_o, phy_clk_gated_o, test_mode_o;
  logic        resume_req = 1'b0;
  logic [1:0]  v;
  lamp_s       lamp_o;
  force_s      force_o;
  pattern_e    pattern_o;
  int          errors = 0;
  int          n_compared = 0;
  usb_port_ctrl_device_fields DUT (.*);
  usb_host_model host (.resume_req_i(resume_req), .phy_clk_o(phy_clk_i), .resume_o(host_resume_i));
  always #5 core_clk_i = ~core_clk_i;
  task automatic close_out;
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
    if (n == 50) begin
      errors++;
      $display("ERROR %0t bus timeout", $time);
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 4'hF, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(8'h00);
    chk(q, 32'h0);
    for (int i = 1; i < 5; i++) begin
      v = 2'(i % 4);
      wb(1'b1, 8'h00, 4'h2, {16'h0, v, 14'h0});
      rd(8'h00);
      chk(q & 32'h0000C000, {16'h0, v, 14'h0});
      rd(8'h04);
      chk(q & 32'h3, 32'(v));
      chk(32'(lamp_o), 32'({v == 2'h1, v == 2'h2}));
    end
    // Indicator output register written on its own
    wb(1'b1, 8'h04, 4'h1, 32'h1);
    chk(32'(lamp_o), 32'h2);
    rd(8'h00);
    chk(q & 32'h0000C000, 32'h0);
    for (int c = 1; c < 16; c++) begin
      wb(1'b1, 8'h00, 4'h4, {8'h0, 4'h7, c[3:0], 16'h0});
      rd(8'h00);
      chk(q & 32'h00FF0000, {12'h0, c[3:0], 16'h0});
      chk(32'(test_mode_o), 32'h1);
      chk(32'(pattern_o), (c < 5) ? 32'(c) : 32'h0);
      chk(32'(force_o), (c == 5) ? 32'h3 : (c == 6) ? 32'h2 : 32'h0);
    end
    wb(1'b1, 8'h00, 4'h4, 32'h0);
    chk(32'({test_mode_o, force_o}), 32'h0);
    wb(1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF);
    rd(8'h0C);
    chk(q, 32'h0);
    // Gate while stopped, then ungate; gate and resume come after the reset check
    wb(1'b1, 8'h00, 4'h4, 32'h00800000);
    rd(8'h00);
    chk(32'({q[23], phy_clk_gated_o}), 32'h3);
    wb(1'b1, 8'h00, 4'h4, 32'h0);
    rd(8'h00);
    chk(32'({q[23], phy_clk_gated_o}), 32'h0);
    // Reset in mid-run returns every field to zero
    wb(1'b1, 8'h00, 4'h6, 32'h0085C000);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(8'h00);
    chk(q, 32'h0);
    chk(32'({test_mode_o, force_o, phy_clk_gated_o}), 32'h0);
    rd(8'h04);
    chk(q, 32'h0);
    wb(1'b1, 8'h00, 4'h4, 32'h00800000);
    chk(32'(phy_clk_gated_o), 32'h1);
    resume_req <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    rd(8'h00);
    chk(32'({q[23], phy_clk_gated_o}), 32'h0);
    resume_req <= 1'b0;
    close_out();
  end
endmodule
